//--- rtl/sss_sequencer.sv
/*
  Stop sequencer of the drive state machine: deceleration and the
  following state on Shutdown, Disable operation and halt.
  Assumes the command decoder supplies one-cycle accepted pulses and
  that all inputs are synchronous to clk.
*/
//
// Function
// - Shutdown accepted in operation enabled starts deceleration per the shutdown option.
// - While a commanded deceleration runs the reported state stays operation enabled.
// - The motor counts as stopped only at 30 r/min or below, and only then is the stop finished.
// - After the shutdown stop the state becomes ready to switch on.
// - The voltage-enabled status bit 4 stays one through the shutdown stop.
// - Disable-operation option is signed 16-bit, legal 0 to 1, other writes ignored.
// - Disable operation accepted starts deceleration while operation enabled is reported.
// - After the disable-operation stop the state becomes switched on.
// - A 0-to-1 change of control word bit 8 starts a halt deceleration.
// - After a halt stop the state stays operation enabled.
// - Halt option is signed 16-bit, legal 1 to 3, selecting the halt deceleration method.
// - In homing mode shutdown option 1 stops by homing acceleration, then ready to switch on.
`timescale 1ns/1ps
module sss_sequencer
  import sss_pkg::*;
#(
  parameter int VEL_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  input wire logic cmd_shutdown,
  input wire logic cmd_disable_op,
  input wire logic cmd_switch_on,
  input wire logic cmd_enable_op,
  input wire logic [15:0] control_word,
  input wire sss_mode_t op_mode,
  input wire logic signed [VEL_W-1:0] actual_vel,
  output logic [31:0] obj_rdata,
  output logic obj_rd_valid,
  output logic obj_unmapped,
  output sss_report_t drive_state,
  output logic [15:0] status_word,
  output logic decel_active,
  output sss_src_t decel_src,
  output logic [31:0] decel_rate
);

  initial begin
    if (VEL_W < 8) begin
      $error("sss_sequencer: VEL_W too small");
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] v, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    logic signed [15:0] s;
    s = signed'(v[15:0]);
    return (s >= lo) && (s <= hi);
  endfunction

  function automatic sss_src_t mode_rate(input sss_mode_t m);
    unique case (m)
      SSS_MODE_HOMING: return SSS_SRC_HOMING;
      SSS_MODE_TORQUE: return SSS_SRC_TORQUE;
      default: return SSS_SRC_PROFILE;
    endcase
  endfunction

  function automatic sss_report_t report(input sss_state_t s);
    unique case (s)
      SSS_S_READY: return SSS_DS_READY;
      SSS_S_SWON: return SSS_DS_SWON;
      default: return SSS_DS_OPEN;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Object store
  // ----------------------------------------------------------------
  logic [15:0] servo_off_seq_ff;
  logic [15:0] dis_op_sel_ff;
  logic [15:0] halt_sel_ff;
  logic [15:0] shut_sel_ff;
  logic [31:0] prof_decel_ff;
  logic [31:0] torque_ramp_ff;
  logic [31:0] homing_accel_ff;

  // Out-of-range option writes are dropped so the active choice stays legal
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      servo_off_seq_ff <= OPT_RST;
      dis_op_sel_ff <= OPT_RST;
      halt_sel_ff <= HALT_RST;
      shut_sel_ff <= OPT_RST;
      prof_decel_ff <= RATE_RST;
      torque_ramp_ff <= RATE_RST;
      homing_accel_ff <= RATE_RST;
    end else if (obj_wr) begin
      unique case (obj_index)
        IDX_SERVO_OFF_SEQ: begin
          if (in_range(obj_wdata, SERVO_OFF_MIN, SERVO_OFF_MAX)) begin
            servo_off_seq_ff <= obj_wdata[15:0];
          end
        end
        IDX_DIS_OP_SEL: begin
          if (in_range(obj_wdata, DIS_OP_MIN, DIS_OP_MAX)) begin
            dis_op_sel_ff <= obj_wdata[15:0];
          end
        end
        IDX_HALT_SEL: begin
          if (in_range(obj_wdata, HALT_MIN, HALT_MAX)) begin
            halt_sel_ff <= obj_wdata[15:0];
          end
        end
        IDX_SHUT_SEL: begin
          if (in_range(obj_wdata, SHUT_MIN, SHUT_MAX)) begin
            shut_sel_ff <= obj_wdata[15:0];
          end
        end
        IDX_PROF_DECEL: prof_decel_ff <= obj_wdata;
        IDX_TORQUE_RAMP: torque_ramp_ff <= obj_wdata;
        IDX_HOMING_ACCEL: homing_accel_ff <= obj_wdata;
        default: ;
      endcase
    end
  end

  // Read answer one cycle after obj_rd; unknown index answers zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      obj_rdata <= 32'h0000_0000;
      obj_rd_valid <= 1'b0;
      obj_unmapped <= 1'b0;
    end else begin
      obj_rd_valid <= obj_rd;
      obj_unmapped <= 1'b0;
      obj_rdata <= 32'h0000_0000;
      if (obj_rd) begin
        unique case (obj_index)
          IDX_SERVO_OFF_SEQ: obj_rdata <= {{16{servo_off_seq_ff[15]}}, servo_off_seq_ff};
          IDX_DIS_OP_SEL: obj_rdata <= {{16{dis_op_sel_ff[15]}}, dis_op_sel_ff};
          IDX_HALT_SEL: obj_rdata <= {{16{halt_sel_ff[15]}}, halt_sel_ff};
          IDX_SHUT_SEL: obj_rdata <= {{16{shut_sel_ff[15]}}, shut_sel_ff};
          IDX_PROF_DECEL: obj_rdata <= prof_decel_ff;
          IDX_TORQUE_RAMP: obj_rdata <= torque_ramp_ff;
          IDX_HOMING_ACCEL: obj_rdata <= homing_accel_ff;
          default: obj_unmapped <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Stop detection and halt edge
  // ----------------------------------------------------------------
  logic stopped;
  logic halt_prev_ff;
  logic halt_rise;

  sss_stop_detect #(.VEL_W(VEL_W), .THRESH(STOP_RPM)) u_stop (
    .clk(clk),
    .resetn(resetn),
    .actual_vel(actual_vel),
    .stopped(stopped)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      halt_prev_ff <= 1'b0;
    end else begin
      halt_prev_ff <= control_word[CW_HALT_BIT];
    end
  end

  assign halt_rise = control_word[CW_HALT_BIT] && !halt_prev_ff;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  sss_state_t state_ff;
  sss_state_t nxt_state;

  // Shutdown outranks Disable operation, which outranks a halt
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SSS_S_ENABLED, SSS_S_HALT, SSS_S_HALTED: begin
        if (cmd_shutdown) begin
          nxt_state = SSS_S_SHUT;
        end else if (cmd_disable_op) begin
          nxt_state = SSS_S_DISOP;
        end else if (state_ff == SSS_S_ENABLED && halt_rise) begin
          nxt_state = SSS_S_HALT;
        end else if (state_ff == SSS_S_HALT && stopped) begin
          nxt_state = SSS_S_HALTED;
        end else if (state_ff != SSS_S_ENABLED && !control_word[CW_HALT_BIT]) begin
          nxt_state = SSS_S_ENABLED;
        end
      end
      SSS_S_SHUT: begin
        if (stopped) begin
          nxt_state = SSS_S_READY;
        end
      end
      SSS_S_DISOP: begin
        if (stopped) begin
          nxt_state = SSS_S_SWON;
        end else if (cmd_shutdown) begin
          nxt_state = SSS_S_SHUT;
        end
      end
      SSS_S_READY: begin
        if (cmd_switch_on) begin
          nxt_state = SSS_S_SWON;
        end
      end
      SSS_S_SWON: begin
        if (cmd_shutdown) begin
          nxt_state = SSS_S_READY;
        end else if (cmd_enable_op) begin
          nxt_state = SSS_S_ENABLED;
        end
      end
      default: nxt_state = SSS_S_SWON;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SSS_S_SWON;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Deceleration choice and reported outputs
  // ----------------------------------------------------------------
  sss_src_t nxt_src;
  logic [31:0] nxt_rate;

  always_comb begin
    nxt_src = SSS_SRC_NONE;
    unique case (nxt_state)
      SSS_S_SHUT: begin
        nxt_src = (shut_sel_ff == 16'h0001) ? mode_rate(op_mode) : SSS_SRC_SERVO_OFF;
      end
      SSS_S_DISOP: begin
        nxt_src = (dis_op_sel_ff == 16'h0001) ? mode_rate(op_mode) : SSS_SRC_SERVO_OFF;
      end
      SSS_S_HALT: begin
        unique case (halt_sel_ff)
          16'h0002: nxt_src = SSS_SRC_HALT2;
          16'h0003: nxt_src = SSS_SRC_HALT3;
          default: nxt_src = mode_rate(op_mode);
        endcase
      end
      default: nxt_src = SSS_SRC_NONE;
    endcase
  end

  // Quick-stop and limit rates live outside this block, so they give zero here
  always_comb begin
    unique case (nxt_src)
      SSS_SRC_PROFILE: nxt_rate = prof_decel_ff;
      SSS_SRC_HOMING: nxt_rate = homing_accel_ff;
      SSS_SRC_TORQUE: nxt_rate = torque_ramp_ff;
      default: nxt_rate = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_state <= SSS_DS_SWON;
      status_word <= 16'h0000;
      decel_active <= 1'b0;
      decel_src <= SSS_SRC_NONE;
      decel_rate <= 32'h0000_0000;
    end else begin
      drive_state <= report(nxt_state);
      status_word <= 16'h0000;
      status_word[SW_VOLT_BIT] <= 1'b1;
      decel_active <= (nxt_src != SSS_SRC_NONE);
      decel_src <= nxt_src;
      decel_rate <= nxt_rate;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_shut_starts: assert property ((state_ff == SSS_S_ENABLED) && cmd_shutdown
    |=> (state_ff == SSS_S_SHUT) && decel_active)
    else $error("shutdown did not start deceleration");
  a_decel_reports_open: assert property ((state_ff inside {SSS_S_SHUT, SSS_S_DISOP,
    SSS_S_HALT}) |-> (drive_state == SSS_DS_OPEN))
    else $error("deceleration left operation enabled");
  a_no_early_stop: assert property ((state_ff == SSS_S_SHUT) && !stopped
    |=> (state_ff == SSS_S_SHUT))
    else $error("shutdown finished before motor stopped");
  a_shut_to_ready: assert property ((state_ff == SSS_S_SHUT) && stopped
    |=> (state_ff == SSS_S_READY) && (drive_state == SSS_DS_READY))
    else $error("shutdown stop did not reach ready");
  a_volt_held: assert property ((state_ff == SSS_S_SHUT) |-> status_word[SW_VOLT_BIT])
    else $error("voltage enabled dropped");
  a_disop_range: assert property (obj_wr && (obj_index == IDX_DIS_OP_SEL)
    && !in_range(obj_wdata, DIS_OP_MIN, DIS_OP_MAX) |=> $stable(dis_op_sel_ff))
    else $error("illegal disable option stored");
  a_disop_starts: assert property ((state_ff == SSS_S_ENABLED) && cmd_disable_op
    && !cmd_shutdown |=> (state_ff == SSS_S_DISOP) && (drive_state == SSS_DS_OPEN))
    else $error("disable operation did not decelerate");
  a_disop_to_swon: assert property ((state_ff == SSS_S_DISOP) && stopped
    |=> (drive_state == SSS_DS_SWON))
    else $error("disable stop did not reach switched on");
  a_halt_edge: assert property ((state_ff == SSS_S_ENABLED) && !cmd_shutdown
    && !cmd_disable_op && !halt_prev_ff && control_word[CW_HALT_BIT]
    |=> (state_ff == SSS_S_HALT))
    else $error("halt edge ignored");
  a_halted_stays: assert property ((state_ff == SSS_S_HALT) && stopped && !cmd_shutdown
    && !cmd_disable_op |=> (state_ff == SSS_S_HALTED) ##0 (drive_state == SSS_DS_OPEN))
    else $error("halt stop left operation enabled");
  a_halt_range: assert property (obj_wr && (obj_index == IDX_HALT_SEL)
    && !in_range(obj_wdata, HALT_MIN, HALT_MAX) |=> $stable(halt_sel_ff))
    else $error("illegal halt option stored");
  a_homing_rate: assert property ((nxt_state == SSS_S_SHUT) && (op_mode == SSS_MODE_HOMING)
    && (shut_sel_ff == 16'h0001) |=> (decel_src == SSS_SRC_HOMING)
    && (decel_rate == $past(homing_accel_ff)))
    else $error("homing shutdown rate wrong");
  a_disop_servo: assert property ((nxt_state == SSS_S_DISOP) && (dis_op_sel_ff == 16'h0000)
    |=> (decel_src == SSS_SRC_SERVO_OFF))
    else $error("disable option 0 not servo-off");
  a_rate_store: assert property (obj_wr && (obj_index == IDX_PROF_DECEL)
    ##1 obj_rd && (obj_index == IDX_PROF_DECEL) |=> (obj_rdata == $past(obj_wdata, 2)))
    else $error("profile deceleration readback wrong");

  c_shut_seq: cover property ((state_ff == SSS_S_SHUT) ##[1:50] (state_ff == SSS_S_READY));
  c_disop_seq: cover property ((state_ff == SSS_S_DISOP) ##[1:50] (state_ff == SSS_S_SWON));
  c_halt_seq: cover property ((state_ff == SSS_S_HALT) ##[1:50] (state_ff == SSS_S_HALTED));
  c_bad_write: cover property (obj_wr && (obj_index == IDX_HALT_SEL) && (obj_wdata == 32'h0));

endmodule

//--- rtl/sss_pkg.sv
/*
  Shared constants and types of the servo stop option sequencer.
  Assumes one drive control clock and velocity feedback in r/min.
*/
package sss_pkg;

  // ----------------------------------------------------------------
  // Object indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SERVO_OFF_SEQ = 16'h3506;
  localparam logic [15:0] IDX_DIS_OP_SEL = 16'h605C;
  localparam logic [15:0] IDX_HALT_SEL = 16'h605D;
  localparam logic [15:0] IDX_PROF_DECEL = 16'h6084;
  localparam logic [15:0] IDX_TORQUE_RAMP = 16'h6087;
  localparam logic [15:0] IDX_HOMING_ACCEL = 16'h609A;
  localparam logic [15:0] IDX_SHUT_SEL = 16'h3F00;

  // ----------------------------------------------------------------
  // Legal option ranges and reset values
  // ----------------------------------------------------------------
  localparam logic signed [15:0] DIS_OP_MIN = 16'sh0000;
  localparam logic signed [15:0] DIS_OP_MAX = 16'sh0001;
  localparam logic signed [15:0] SHUT_MIN = 16'sh0000;
  localparam logic signed [15:0] SHUT_MAX = 16'sh0001;
  localparam logic signed [15:0] HALT_MIN = 16'sh0001;
  localparam logic signed [15:0] HALT_MAX = 16'sh0003;
  localparam logic signed [15:0] SERVO_OFF_MIN = 16'sh0000;
  localparam logic signed [15:0] SERVO_OFF_MAX = 16'sh0009;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [15:0] HALT_RST = 16'h0001;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Control / status word fields and stop threshold
  // ----------------------------------------------------------------
  localparam int CW_HALT_BIT = 8;
  localparam int SW_VOLT_BIT = 4;
  localparam int STOP_RPM = 30;

  typedef enum logic [1:0] {
    SSS_MODE_POSVEL = 2'h0,
    SSS_MODE_HOMING = 2'h1,
    SSS_MODE_TORQUE = 2'h2
  } sss_mode_t;

  typedef enum logic [2:0] {
    SSS_DS_READY = 3'h1,
    SSS_DS_SWON = 3'h2,
    SSS_DS_OPEN = 3'h4
  } sss_report_t;

  typedef enum logic [6:0] {
    SSS_S_ENABLED = 7'h01,
    SSS_S_SHUT = 7'h02,
    SSS_S_DISOP = 7'h04,
    SSS_S_HALT = 7'h08,
    SSS_S_HALTED = 7'h10,
    SSS_S_READY = 7'h20,
    SSS_S_SWON = 7'h40
  } sss_state_t;

  typedef enum logic [2:0] {
    SSS_SRC_NONE = 3'h0,
    SSS_SRC_SERVO_OFF = 3'h1,
    SSS_SRC_PROFILE = 3'h2,
    SSS_SRC_HOMING = 3'h3,
    SSS_SRC_TORQUE = 3'h4,
    SSS_SRC_HALT2 = 3'h5,
    SSS_SRC_HALT3 = 3'h6
  } sss_src_t;

endpackage

//--- rtl/sss_stop_detect.sv
/*
  Motor-stopped detector: flags when |actual velocity| is at or below
  the stop threshold. Assumes velocity is a signed count in r/min.
*/
`timescale 1ns/1ps
module sss_stop_detect
  import sss_pkg::*;
#(
  parameter int VEL_W = 32,
  parameter int THRESH = STOP_RPM
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic signed [VEL_W-1:0] actual_vel,
  output logic stopped
);

  initial begin
    if (VEL_W < 8 || THRESH < 0) begin
      $error("sss_stop_detect: bad parameters");
    end
  end

  localparam logic signed [VEL_W-1:0] LIM = VEL_W'(THRESH);

  // Threshold is inclusive on both signs; no abs() so the most
  // negative value cannot overflow into a false stop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stopped <= 1'b1;
    end else begin
      stopped <= (actual_vel <= LIM) && (actual_vel >= -LIM);
    end
  end

  a_stop_thresh: assert property (@(posedge clk) disable iff (!resetn)
    (actual_vel > LIM) |=> !stopped)
    else $error("stopped flagged above threshold");

endmodule

//--- tb/sss_motor_model.sv
/*
  Motor stand-in on the far side: speed ramps down while the drive decelerates.
  Assumes the bench loads a speed and may freeze it to probe the stop edge.
*/
`timescale 1ns/1ps
module sss_motor_model #(
  parameter int VEL_W = 32,
  parameter int STEP = 100
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic decel_active,
  input wire logic load,
  input wire logic signed [VEL_W-1:0] load_vel,
  input wire logic hold,
  output logic signed [VEL_W-1:0] actual_vel
);
  logic signed [VEL_W-1:0] vel_ff;

  assign actual_vel = vel_ff;

  // Clamped at zero so the stop threshold is crossed once, never oscillated
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vel_ff <= '0;
    end else if (load) begin
      vel_ff <= load_vel;
    end else if (decel_active && !hold && vel_ff > 0) begin
      vel_ff <= (vel_ff > STEP) ? vel_ff - STEP : '0;
    end
  end
endmodule

//--- tb/sss_sequencer_test.sv
/*
  Self-checking bench of the stop sequencer: object access, every stop kind
  in every mode and option, and the stop threshold.
  Assumes the motor model as far side and a 100 MHz clock.
*/
`timescale 1ns/1ps
module sss_sequencer_test
  import sss_pkg::*;
;
  localparam logic [31:0] R_PROF = 32'h8000_1234;
  localparam logic [31:0] R_HOME = 32'hFFFF_FFFE;
  localparam logic [31:0] R_TORQ = 32'h0000_5678;
  localparam logic [15:0] W_IDX [9] = '{IDX_PROF_DECEL, IDX_HOMING_ACCEL, IDX_TORQUE_RAMP,
    IDX_DIS_OP_SEL, IDX_DIS_OP_SEL, IDX_DIS_OP_SEL, IDX_HALT_SEL, IDX_HALT_SEL, IDX_HALT_SEL};
  localparam logic [31:0] W_DAT [9] = '{R_PROF, R_HOME, R_TORQ, 32'h2, 32'hFFFF, 32'h1,
    32'h0, 32'h4, 32'h3};
  localparam logic [31:0] W_EXP [9] = '{R_PROF, R_HOME, R_TORQ, 32'h0, 32'h0, 32'h1,
    32'h1, 32'h1, 32'h3};
  logic clk, resetn, obj_wr, obj_rd, load, hold;
  logic cmd_shutdown, cmd_disable_op, cmd_switch_on, cmd_enable_op;
  logic obj_rd_valid, obj_unmapped, decel_active;
  logic [15:0] obj_index, control_word, status_word;
  logic [31:0] obj_wdata, obj_rdata, decel_rate;
  logic signed [31:0] actual_vel, load_vel;
  sss_mode_t op_mode;
  sss_report_t drive_state;
  sss_src_t decel_src;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int i, k, m, o;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sss_sequencer DUT (.clk(clk), .resetn(resetn), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .cmd_shutdown(cmd_shutdown),
    .cmd_disable_op(cmd_disable_op), .cmd_switch_on(cmd_switch_on),
    .cmd_enable_op(cmd_enable_op), .control_word(control_word), .op_mode(op_mode),
    .actual_vel(actual_vel), .obj_rdata(obj_rdata), .obj_rd_valid(obj_rd_valid),
    .obj_unmapped(obj_unmapped), .drive_state(drive_state), .status_word(status_word),
    .decel_active(decel_active), .decel_src(decel_src), .decel_rate(decel_rate));

  sss_motor_model motor (.clk(clk), .resetn(resetn), .decel_active(decel_active),
    .load(load), .load_vel(load_vel), .hold(hold), .actual_vel(actual_vel));

  // ----------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------
  task automatic bad(input string msg);
    errors++;
    $display("BAD t=%0t %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) bad($sformatf("%s got %b exp %b", what, got, exp));
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask
  task automatic chk_state(input sss_report_t got, input sss_report_t exp, input string what);
    checked++;
    if (got !== exp) bad($sformatf("%s got %b exp %b", what, got, exp));
  endtask
  task automatic chk_src(input sss_src_t got, input sss_src_t exp, input string what);
    checked++;
    if (got !== exp) bad($sformatf("%s got %0d exp %0d", what, got, exp));
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic obj_write(input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    obj_wr <= 1'b1;
    obj_index <= idx;
    obj_wdata <= d;
    @(posedge clk);
    obj_wr <= 1'b0;
  endtask
  task automatic obj_read(input logic [15:0] idx, input logic [31:0] exp, input logic unm);
    @(posedge clk);
    obj_rd <= 1'b1;
    obj_index <= idx;
    @(posedge clk);
    obj_rd <= 1'b0;
    #1;
    chk_bit(obj_rd_valid, 1'b1, "read valid");
    chk_bit(obj_unmapped, unm, "unmapped flag");
    chk_word(obj_rdata, exp, "read data");
  endtask
  // Commands: 0 shutdown, 1 disable operation, 2 switch on, 3 enable operation
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: cmd_shutdown <= 1'b1;
      1: cmd_disable_op <= 1'b1;
      2: cmd_switch_on <= 1'b1;
      default: cmd_enable_op <= 1'b1;
    endcase
    @(posedge clk);
    {cmd_shutdown, cmd_disable_op, cmd_switch_on, cmd_enable_op} <= 4'h0;
    #1;
  endtask

  function automatic sss_src_t mode_src(input sss_mode_t md);
    case (md)
      SSS_MODE_HOMING: return SSS_SRC_HOMING;
      SSS_MODE_TORQUE: return SSS_SRC_TORQUE;
      default: return SSS_SRC_PROFILE;
    endcase
  endfunction
  function automatic logic [31:0] src_rate(input sss_src_t s);
    case (s)
      SSS_SRC_PROFILE: return R_PROF;
      SSS_SRC_HOMING: return R_HOME;
      SSS_SRC_TORQUE: return R_TORQ;
      default: return 32'h0;
    endcase
  endfunction

  // Stop kinds: 0 shutdown, 1 disable operation, 2 halt bit
  task automatic run_stop(input int kind, input int opt, input sss_mode_t md);
    sss_src_t es;
    sss_report_t fin;
    int n;
    es = (kind != 2) ? (opt == 0 ? SSS_SRC_SERVO_OFF : mode_src(md)) :
      (opt == 2 ? SSS_SRC_HALT2 : (opt == 3 ? SSS_SRC_HALT3 : mode_src(md)));
    fin = (kind == 0) ? SSS_DS_READY : ((kind == 1) ? SSS_DS_SWON : SSS_DS_OPEN);
    obj_write(kind == 0 ? IDX_SHUT_SEL : (kind == 1 ? IDX_DIS_OP_SEL : IDX_HALT_SEL), 32'(opt));
    op_mode <= md;
    load <= 1'b1;
    load_vel <= 32'sh3E8;
    @(posedge clk);
    load <= 1'b0;
    if (kind == 2) begin
      @(posedge clk);
      control_word[CW_HALT_BIT] <= 1'b1;
      @(posedge clk);
      #1;
    end else begin
      pulse(kind);
    end
    chk_bit(decel_active, 1'b1, "decel start");
    chk_src(decel_src, es, "decel method");
    chk_word(decel_rate, src_rate(es), "decel rate");
    chk_state(drive_state, SSS_DS_OPEN, "state in decel");
    chk_bit(status_word[SW_VOLT_BIT], 1'b1, "voltage enabled");
    n = 0;
    while (decel_active !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(decel_active, 1'b0, "decel end");
    chk_state(drive_state, fin, "state after stop");
    if (kind == 2) begin
      @(posedge clk);
      control_word <= 16'h0000;
    end
    if (kind == 0) pulse(2);
    if (kind != 2) pulse(3);
    @(posedge clk);
    #1;
    chk_state(drive_state, SSS_DS_OPEN, "back to enabled");
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {obj_wr, obj_rd, load, hold} = 4'h0;
    {cmd_shutdown, cmd_disable_op, cmd_switch_on, cmd_enable_op} = 4'h0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0;
    control_word = 16'h0000;
    load_vel = 32'sh0;
    op_mode = SSS_MODE_POSVEL;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk_state(drive_state, SSS_DS_SWON, "reset state");
    chk_word({16'h0000, status_word}, 32'h0000_0010, "status word");
    obj_read(IDX_DIS_OP_SEL, 32'h0, 1'b0);
    obj_read(IDX_HALT_SEL, 32'h1, 1'b0);
    obj_read(IDX_PROF_DECEL, 32'h0, 1'b0);
    // Out-of-range option writes must leave the previous value in place
    for (i = 0; i < 9; i++) begin
      obj_write(W_IDX[i], W_DAT[i]);
      obj_read(W_IDX[i], W_EXP[i], 1'b0);
    end
    obj_read(16'h1234, 32'h0, 1'b1);
    // Write then read on the very next edge must return the new value
    @(posedge clk);
    obj_wr <= 1'b1;
    obj_index <= IDX_PROF_DECEL;
    obj_wdata <= R_TORQ;
    @(posedge clk);
    obj_wr <= 1'b0;
    obj_rd <= 1'b1;
    @(posedge clk);
    obj_rd <= 1'b0;
    #1;
    chk_word(obj_rdata, R_TORQ, "back-to-back read");
    obj_write(IDX_PROF_DECEL, R_PROF);
    $display("test objects done");
    pulse(3);
    chk_state(drive_state, SSS_DS_OPEN, "enabled");
    for (k = 0; k < 3; k++) begin
      for (m = 0; m < 3; m++) begin
        for (o = (k == 2 ? 1 : 0); o <= (k == 2 ? 3 : 1); o++) begin
          run_stop(k, o, sss_mode_t'(2'(m)));
        end
      end
      $display("test stop kind %0d done", k);
    end
    // Negative speed just above the threshold must not finish the stop
    obj_write(IDX_SHUT_SEL, 32'h0);
    op_mode <= SSS_MODE_POSVEL;
    load <= 1'b1;
    load_vel <= 32'sh3E8;
    @(posedge clk);
    load <= 1'b0;
    pulse(0);
    hold <= 1'b1;
    load <= 1'b1;
    load_vel <= -32'sh1F;
    @(posedge clk);
    load <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(decel_active, 1'b1, "31 r/min not stopped");
    chk_state(drive_state, SSS_DS_OPEN, "31 r/min state");
    @(posedge clk);
    load <= 1'b1;
    load_vel <= -32'sh1E;
    @(posedge clk);
    load <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(decel_active, 1'b0, "30 r/min stopped");
    chk_state(drive_state, SSS_DS_READY, "30 r/min state");
    hold <= 1'b0;
    $display("test threshold done");
    conclude();
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad("timeout");
      conclude();
    end
  end
endmodule
